// file: rtl/cct_codec_ctrl.sv
// Behaviour
// R1: sidetone code steps -12 dB at 000 by -2 dB down to -24 dB at 110
// R2: power bit 7 mutes sidetone regardless of gain code
// R3: sidetone gain resets to the -12 dB code
// R4: volume code steps 0 dB at 0000 by -2 dB down to -18 dB at 1001
// R5: volume resets to 0 dB
// R6: power bit 3 mutes the earphone
// R7: companded receive sample is 8 bits, MSB first, slots 1 to 8
// R8: linear receive sample is 15 bits, MSB first, slot 16 unused
// R9: gain control bits follow the voice sample and are not taken as data
// R10: host loads tone code as frequency over 7.8125 Hz, rounded
// R11: high tone register at 04, low at 05; high tone 2 dB louder
// R12: host puts high group in register 04, low group in 05
// R13: loading a tone code starts an iterative table look-up of 6/7-bit samples
// R14: tones go to every output; only output enables decide audibility; here mode bit 6 also zeroes the tone sum
// R15: buzzer carries a pulse-density stream of the selected tones
// R16: all internal timing derives from the one master clock
// R17: slave only; serial clock is never driven
// R18: data line is driven low or released, never high
// R19: answers address byte E2 for writes and E3 for reads
// R20: data changes only while clock low; changes in clock high are start/stop
// R21: data fall with clock high is start; every command begins with one
// R22: data rise with clock high is stop; every operation ends with one
// R23: addressed device pulls data low on the ninth clock of each byte
// R24: master nack ends a read; device then releases data for stop
// R25: sidetone gain is bits 2 to 0 of register 02
// R26: earphone volume is bits 3 to 0 of register 03
// R27: first write byte after address picks index, next byte is stored there
`timescale 1ns/100ps
`default_nettype none
module cct_codec_ctrl #(
  parameter int TICK_CYCLES = cct_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // two-wire control port
  input  wire logic        scl,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // receive voice stream
  input  wire logic        pcm_frame,
  input  wire logic        pcm_bit_en,
  input  wire logic        pcm_din,
  output logic             rx_fifo_ready,
  // received samples out
  output logic      [14:0] rx_sample_data,
  output logic             rx_sample_valid,
  input  wire logic        rx_sample_ready,
  // gain and mute controls
  output logic      [4:0]  side_atten_db,
  output logic             side_mute,
  output logic      [4:0]  vol_atten_db,
  output logic             ear_mute,
  output logic             ear_sel_diff,
  // tone and buzzer
  output logic      [6:0]  tone_hi_sample,
  output logic      [5:0]  tone_lo_sample,
  output logic      [7:0]  tone_sample,
  output logic             buzzer_pdm_out
);

  typedef struct packed {
    cct_pkg::cct_bus_st_t       st;
    cct_pkg::cct_bus_st_t       ack_to;
    logic [3:0]                 cnt;
    logic [7:0]                 sr;
    logic [7:0]                 idx;
    logic                       sda_oe;
    logic                       scl_q;
    logic                       sda_q;
    logic [5:0][7:0]            regs;
    logic [15:0]                tick_cnt;
    cct_pkg::cct_tone_st_t      tst;
    logic [cct_pkg::PHASE_W-1:0] acc_hi;
    logic [cct_pkg::PHASE_W-1:0] acc_lo;
    logic [6:0]                 hi;
    logic [5:0]                 lo;
    logic [7:0]                 sum;
    logic [8:0]                 pdm_acc;
    logic                       pdm;
    logic [4:0]                 slot;
    logic [13:0]                rx_sr;
    logic                       push_v;
    logic [14:0]                push_d;
  } cct_st_t;

  cct_st_t     q;
  cct_st_t     n;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic [7:0]  rd_val;
  logic        comp_mode;
  logic [4:0]  rx_width;
  logic [4:0]  slot_nxt;
  logic [6:0]  look;
  logic [2:0]  side_code;
  logic [3:0]  vol_code;

  // magnitude from the quarter-wave table, mirrored and negated per quadrant
  function automatic logic [6:0] sine_look(input logic [9:0] ph, input logic loud);
    logic [3:0]  i;
    logic [4:0]  m;
    logic [11:0] p;
    logic [6:0]  v;
    begin
      i = ph[8] ? ~ph[7:4] : ph[7:4];
      m = cct_pkg::SINE_Q[i];
      p = loud ? ((12'(m) * 12'(cct_pkg::HI_NUM)) >> cct_pkg::HI_SHIFT) : 12'(m);
      v = {1'b0, p[5:0]};
      return ph[9] ? 7'(-v) : v;
    end
  endfunction

  // line events; inputs are already in the clock domain
  assign scl_rise  = scl & ~q.scl_q;
  assign scl_fall  = ~scl & q.scl_q;
  assign bus_start = scl & q.scl_q & q.sda_q & ~sda_i;  // see R21
  assign bus_stop  = scl & q.scl_q & ~q.sda_q & sda_i;  // see R22

  // read-back; unmapped indices read as zero
  assign rd_val = (q.idx < cct_pkg::NUM_REGS) ? q.regs[q.idx[2:0]] : cct_pkg::RD_UNMAPPED;

  // open drain: only ever pull low, scl is an input only
  assign sda_o  = 1'b0;     // see R18
  assign sda_oe = q.sda_oe; // see R17

  // receive slot width follows the companding mode
  assign comp_mode = q.regs[cct_pkg::IDX_MODE[2:0]][cct_pkg::MODE_COMP_EN_BIT];
  assign rx_width  = comp_mode ? cct_pkg::COMP_BITS : cct_pkg::LIN_BITS; // see R7 see R8
  assign slot_nxt  = pcm_frame ? cct_pkg::SLOT_FIRST :
                     (q.slot == cct_pkg::SLOT_BITS) ? q.slot : q.slot + 1'b1;
  assign look      = sine_look((q.tst == cct_pkg::T_HI) ? q.acc_hi : q.acc_lo,
                               q.tst == cct_pkg::T_HI);

  always_comb begin
    n          = q;
    n.scl_q    = scl;
    n.sda_q    = sda_i;
    n.push_v   = 1'b0;
    // two-wire slave; bits sampled on rising scl, driven after falling scl
    if (bus_start) begin
      n.st     = cct_pkg::S_ADDR; // see R21
      n.cnt    = '0;
      n.sda_oe = 1'b0;
    end else if (bus_stop) begin
      n.st     = cct_pkg::S_IDLE; // see R22
      n.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        cct_pkg::S_IDLE: begin
          n.sda_oe = 1'b0;
        end
        cct_pkg::S_ADDR, cct_pkg::S_INDEX, cct_pkg::S_WDATA: begin
          if (scl_rise && q.cnt != cct_pkg::BYTE_BITS) begin
            n.sr  = {q.sr[6:0], sda_i}; // see R20
            n.cnt = q.cnt + 1'b1;
          end else if (scl_fall && q.cnt == cct_pkg::BYTE_BITS) begin
            n.cnt    = '0;
            n.sda_oe = 1'b1; // see R23
            n.st     = cct_pkg::S_ACK;
            if (q.st == cct_pkg::S_ADDR) begin
              if (q.sr == cct_pkg::ADDR_WR) begin
                n.ack_to = cct_pkg::S_INDEX; // see R19
              end else if (q.sr == cct_pkg::ADDR_RD) begin
                n.ack_to = cct_pkg::S_RDATA; // see R19
              end else begin
                n.sda_oe = 1'b0;
                n.st     = cct_pkg::S_IDLE;
              end
            end else if (q.st == cct_pkg::S_INDEX) begin
              n.idx    = q.sr; // see R27
              n.ack_to = cct_pkg::S_WDATA;
            end else begin
              // stores, then walks to the next index for burst writes
              if (q.idx < cct_pkg::NUM_REGS) begin
                n.regs[q.idx[2:0]] = q.sr; // see R27
              end
              if (q.idx == cct_pkg::IDX_TONE_HI) begin
                n.acc_hi = '0; // see R13
              end
              if (q.idx == cct_pkg::IDX_TONE_LO) begin
                n.acc_lo = '0; // see R13
              end
              n.idx    = q.idx + 1'b1;
              n.ack_to = cct_pkg::S_WDATA;
            end
          end
        end
        cct_pkg::S_ACK: begin
          // ack released after the ninth clock; reads drive their msb now
          if (scl_fall) begin
            n.cnt = '0;
            n.st  = q.ack_to;
            if (q.ack_to == cct_pkg::S_RDATA) begin
              n.sr     = rd_val;
              n.sda_oe = ~rd_val[7];
            end else begin
              n.sda_oe = 1'b0;
            end
          end
        end
        cct_pkg::S_RDATA: begin
          if (scl_rise) begin
            n.cnt = q.cnt + 1'b1;
          end else if (scl_fall) begin
            if (q.cnt == cct_pkg::BYTE_BITS) begin
              n.sda_oe = 1'b0;
              n.st     = cct_pkg::S_RACK;
            end else begin
              n.sr     = {q.sr[6:0], 1'b0};
              n.sda_oe = ~q.sr[6]; // see R20
            end
          end
        end
        cct_pkg::S_RACK: begin
          // master nack: stay released and wait for the stop
          if (scl_rise) begin
            if (sda_i) begin
              n.st = cct_pkg::S_IDLE; // see R24
            end else begin
              n.idx    = q.idx + 1'b1;
              n.ack_to = cct_pkg::S_RDATA;
              n.st     = cct_pkg::S_ACK;
            end
          end
        end
        default: begin
          n.st = cct_pkg::S_IDLE;
        end
      endcase
    end

    // 8 kHz sample tick from the master clock
    if (q.tick_cnt == 16'(TICK_CYCLES - 1)) begin
      n.tick_cnt = '0; // see R16
    end else begin
      n.tick_cnt = q.tick_cnt + 1'b1;
    end

    // one look-up per cycle, high tone then low, then the sum
    unique case (q.tst)
      cct_pkg::T_IDLE: begin
        if (q.tick_cnt == 16'(TICK_CYCLES - 1)) begin
          n.acc_hi = q.acc_hi + q.regs[cct_pkg::IDX_TONE_HI[2:0]]; // see R11
          n.acc_lo = q.acc_lo + q.regs[cct_pkg::IDX_TONE_LO[2:0]]; // see R11
          n.tst    = cct_pkg::T_HI;
        end
      end
      cct_pkg::T_HI: begin
        n.hi  = look; // see R13
        n.tst = cct_pkg::T_LO;
      end
      cct_pkg::T_LO: begin
        n.lo  = look[5:0]; // see R13
        n.tst = cct_pkg::T_SUM;
      end
      cct_pkg::T_SUM: begin
        if (q.regs[cct_pkg::IDX_MODE[2:0]][cct_pkg::MODE_TONE_EN_BIT]) begin
          n.sum = {q.hi[6], q.hi} + {{2{q.lo[5]}}, q.lo};
        end else begin
          n.sum = '0;
        end
        n.tst = cct_pkg::T_IDLE;
      end
    endcase

    // first-order density modulator on the offset-binary tone sum
    n.pdm_acc = {1'b0, q.pdm_acc[7:0]} + {1'b0, q.sum ^ 8'h80};
    n.pdm     = q.pdm_acc[8] & q.regs[cct_pkg::IDX_MODE[2:0]][cct_pkg::MODE_BUZZ_EN_BIT]; // see R15

    // voice slot capture; bits past the sample width are skipped
    if (pcm_bit_en) begin
      n.slot = slot_nxt;
      if (slot_nxt <= rx_width) begin
        n.rx_sr = {q.rx_sr[12:0], pcm_din}; // see R9
      end
      if (slot_nxt == rx_width) begin
        n.push_v = 1'b1;
        n.push_d = comp_mode ? 15'({q.rx_sr[6:0], pcm_din}) : {q.rx_sr, pcm_din};
      end
    end
  end

  // a sample arriving while the buffer is full is dropped; watch rx_fifo_ready
  cct_fifo #(
    .WIDTH (cct_pkg::SAMPLE_W),
    .DEPTH (cct_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (q.push_v),
    .in_ready  (rx_fifo_ready),
    .in_data   (q.push_d),
    .out_valid (rx_sample_valid),
    .out_ready (rx_sample_ready),
    .out_data  (rx_sample_data)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q          <= '0;
      q.st       <= cct_pkg::S_IDLE;
      q.ack_to   <= cct_pkg::S_IDLE;
      q.tst      <= cct_pkg::T_IDLE;
      q.scl_q    <= 1'b1;
      q.sda_q    <= 1'b1;
      q.regs[cct_pkg::IDX_PWR[2:0]]     <= cct_pkg::RST_PWR;
      q.regs[cct_pkg::IDX_MODE[2:0]]    <= cct_pkg::RST_MODE;
      q.regs[cct_pkg::IDX_TXPGA[2:0]]   <= cct_pkg::RST_TXPGA;   // see R3
      q.regs[cct_pkg::IDX_RXPGA[2:0]]   <= cct_pkg::RST_RXPGA;   // see R5
      q.regs[cct_pkg::IDX_TONE_HI[2:0]] <= cct_pkg::RST_TONE;
      q.regs[cct_pkg::IDX_TONE_LO[2:0]] <= cct_pkg::RST_TONE;
    end else begin
      q <= n;
    end
  end

  // gain decode; code 111 has no step, so it is treated as mute
  assign side_code     = q.regs[cct_pkg::IDX_TXPGA[2:0]][cct_pkg::SIDE_MSB:0]; // see R25
  assign vol_code      = q.regs[cct_pkg::IDX_RXPGA[2:0]][cct_pkg::VOL_MSB:0];  // see R26
  // code 111 is muted anyway; clamp its step so the level never leaves the table
  assign side_atten_db = cct_pkg::SIDE_BASE_DB
                       + {1'b0, (side_code > cct_pkg::SIDE_MAX_CODE) ? cct_pkg::SIDE_MAX_CODE
                                                                   : side_code, 1'b0}; // see R1
  assign side_mute     = q.regs[cct_pkg::IDX_PWR[2:0]][cct_pkg::PWR_SIDE_MUTE_BIT]
                       | (side_code > cct_pkg::SIDE_MAX_CODE);                 // see R2
  assign vol_atten_db  = (vol_code > cct_pkg::VOL_MAX_CODE) ? cct_pkg::VOL_FLOOR_DB
                       : {vol_code, 1'b0};                                     // see R4
  assign ear_mute      = q.regs[cct_pkg::IDX_PWR[2:0]][cct_pkg::PWR_EAR_MUTE_BIT]; // see R6
  assign ear_sel_diff  = q.regs[cct_pkg::IDX_PWR[2:0]][cct_pkg::PWR_EAR_SEL_BIT];

  // tone_hi_sample and tone_lo_sample are offered unconditionally; tone_sample and the buzzer follow the mode enables
  assign tone_hi_sample = q.hi;  // see R14
  assign tone_lo_sample = q.lo;
  assign tone_sample    = q.sum; // see R14
  assign buzzer_pdm_out = q.pdm;

endmodule
`default_nettype wire

// file: rtl/cct_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module cct_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } cct_fifo_st_t;

  cct_fifo_st_t q;
  cct_fifo_st_t n;
  logic         push;
  logic         pop;

  // honest flags straight from the count
  assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer wrap relies on a power-of-two depth
  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wp] = in_data;
      n.wp        = q.wp + 1'b1;
    end
    if (pop) begin
      n.rp = q.rp + 1'b1;
    end
    if (push && !pop) begin
      n.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule
`default_nettype wire

// file: rtl/cct_pkg.sv
package cct_pkg;

  // two-wire slave addressing
  localparam logic [7:0] ADDR_WR   = 8'hE2;
  localparam logic [7:0] ADDR_RD   = 8'hE3;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // register indices
  localparam logic [7:0] IDX_PWR     = 8'h00;
  localparam logic [7:0] IDX_MODE    = 8'h01;
  localparam logic [7:0] IDX_TXPGA   = 8'h02;
  localparam logic [7:0] IDX_RXPGA   = 8'h03;
  localparam logic [7:0] IDX_TONE_HI = 8'h04;
  localparam logic [7:0] IDX_TONE_LO = 8'h05;
  localparam logic [7:0] NUM_REGS    = 8'h06;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // reset values
  localparam logic [7:0] RST_PWR     = 8'hF6;
  localparam logic [7:0] RST_MODE    = 8'h02;
  localparam logic [7:0] RST_TXPGA   = 8'h40;
  localparam logic [7:0] RST_RXPGA   = 8'h70;
  localparam logic [7:0] RST_TONE    = 8'h00;

  // field positions
  localparam int PWR_SIDE_MUTE_BIT = 7;
  localparam int PWR_EAR_MUTE_BIT  = 3;
  localparam int PWR_EAR_SEL_BIT   = 1;
  localparam int MODE_TONE_EN_BIT  = 6;
  localparam int MODE_COMP_EN_BIT  = 4;
  localparam int MODE_BUZZ_EN_BIT  = 3;
  localparam int SIDE_MSB          = 2;
  localparam int VOL_MSB           = 3;

  // gain steps in dB
  localparam logic [4:0] SIDE_BASE_DB  = 5'h0C;
  localparam logic [2:0] SIDE_MAX_CODE = 3'h6;
  localparam logic [3:0] VOL_MAX_CODE  = 4'h9;
  localparam logic [4:0] VOL_FLOOR_DB  = 5'h12;

  // receive voice slot
  localparam logic [4:0] COMP_BITS  = 5'h08;
  localparam logic [4:0] LIN_BITS   = 5'h0F;
  localparam logic [4:0] SLOT_BITS  = 5'h10;
  localparam logic [4:0] SLOT_FIRST = 5'h01;
  localparam int         SAMPLE_W   = 15;
  localparam int         FIFO_DEPTH = 8;

  // timing: sample rate from the master clock
  localparam int CLK_HZ      = 125_000_000;
  localparam int SAMPLE_HZ   = 8_000;
  localparam int TICK_CYCLES = CLK_HZ / SAMPLE_HZ;

  // tone synthesis: 10-bit phase gives 8000/1024 = 7.8125 Hz per code
  localparam int         PHASE_W  = 10;
  localparam logic [6:0] HI_NUM   = 7'h51;
  localparam int         HI_SHIFT = 6;
  localparam logic [15:0][4:0] SINE_Q = {
    5'h1F, 5'h1F, 5'h1E, 5'h1D, 5'h1C, 5'h1B, 5'h19, 5'h17,
    5'h15, 5'h12, 5'h10, 5'h0D, 5'h0A, 5'h08, 5'h05, 5'h02};

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_INDEX, S_WDATA, S_ACK, S_RDATA, S_RACK
  } cct_bus_st_t;

  typedef enum logic [1:0] {
    T_IDLE, T_HI, T_LO, T_SUM
  } cct_tone_st_t;

endpackage

// file: test/cct_codec_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
module cct_codec_ctrl_props (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // two-wire port
  input wire logic        scl,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  // sample fifo
  input wire logic        rx_fifo_ready,
  input wire logic [14:0] rx_sample_data,
  input wire logic        rx_sample_valid,
  input wire logic        rx_sample_ready,
  // gains and tones
  input wire logic [4:0]  side_atten_db,
  input wire logic [4:0]  vol_atten_db,
  input wire logic [6:0]  tone_hi_sample,
  input wire logic [5:0]  tone_lo_sample
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // open drain: never driven high, and a pull really lowers the line
  property p_sda_low; !sda_o && (!sda_oe || !sda_i); endproperty
  a_sda_low: assert property (p_sda_low) else $error("data driven high");
  // data line stands while clock is high
  property p_oe_hold; scl && $past(scl) |-> $stable(sda_oe); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("data moved with clock high");
  // pull-down starts only in a clock low phase
  property p_oe_rise; $rose(sda_oe) |-> !scl && !$past(scl); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("pull-down began badly");
  // values right after reset release
  property p_rst_val; $fell(rst) |-> side_atten_db == 5'h0C && vol_atten_db == 5'h00; endproperty
  a_rst_val: assert property (p_rst_val) else $error("gain after reset wrong");
  property p_side_rng; side_atten_db inside {[5'h0C:5'h18]} && !side_atten_db[0]; endproperty
  a_side_rng: assert property (p_side_rng) else $error("sidetone step wrong");
  property p_vol_rng; vol_atten_db <= 5'h12 && !vol_atten_db[0]; endproperty
  a_vol_rng: assert property (p_vol_rng) else $error("volume step wrong");
  // head of the fifo waits for the consumer
  property p_head; rx_sample_valid && !rx_sample_ready |=> rx_sample_valid && $stable(rx_sample_data); endproperty
  a_head: assert property (p_head) else $error("fifo head lost");
  property p_full; !rx_fifo_ready |-> rx_sample_valid; endproperty
  a_full: assert property (p_full) else $error("full but empty");
  // table look-up stays in 7 and 6 bit magnitude
  property p_tone; $signed(tone_hi_sample) >= -7'sd39 && $signed(tone_hi_sample) <= 7'sd39
    && tone_lo_sample != 6'h20; endproperty
  a_tone: assert property (p_tone) else $error("tone sample out of range");
  c_ack: cover property ($rose(sda_oe));
  c_full: cover property (!rx_fifo_ready);
  c_tone: cover property (tone_hi_sample != 7'h00);
endmodule
bind cct_codec_ctrl cct_codec_ctrl_props u_props (.clock, .rst, .scl, .sda_i, .sda_o, .sda_oe, .rx_fifo_ready,
  .rx_sample_data, .rx_sample_valid, .rx_sample_ready, .side_atten_db, .vol_atten_db, .tone_hi_sample,
  .tone_lo_sample);
`default_nettype wire

// file: test/cct_codec_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module cct_codec_ctrl_tb_top;
  // clock, reset, bus wire
  logic        clock = 1'b0;
  logic        rst;
  logic        scl;
  logic        sda;
  logic        host_pull;
  logic        sda_o;
  logic        sda_oe;
  // voice stream
  logic        pcm_frame;
  logic        pcm_bit_en;
  logic        pcm_din;
  logic        rx_fifo_ready;
  logic [14:0] rx_sample_data;
  logic        rx_sample_valid;
  logic        rx_sample_ready;
  // controls and tones
  logic [4:0]  side_atten_db;
  logic        side_mute;
  logic [4:0]  vol_atten_db;
  logic        ear_mute;
  logic        ear_sel_diff;
  logic [6:0]  tone_hi_sample;
  logic [5:0]  tone_lo_sample;
  logic [7:0]  tone_sample;
  logic        buzzer_pdm_out;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic        ack;
  logic [7:0]  rd;
  logic [7:0]  rd2;

  // pull-up: a released line reads high
  assign sda = !(sda_oe || host_pull);
  cct_codec_ctrl #(.TICK_CYCLES(16)) dut (.clock, .rst, .scl, .sda_i(sda), .sda_o, .sda_oe, .pcm_frame,
    .pcm_bit_en, .pcm_din, .rx_fifo_ready, .rx_sample_data, .rx_sample_valid, .rx_sample_ready,
    .side_atten_db, .side_mute, .vol_atten_db, .ear_mute, .ear_sel_diff, .tone_hi_sample,
    .tone_lo_sample, .tone_sample, .buzzer_pdm_out);
  cct_host_model host (.clock, .scl, .sda_pull(host_pull), .sda);

  always #4 clock = ~clock;
  // hang guard, well above the expected run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    host.start();
    host.byte_tx(cct_pkg::ADDR_WR, ack);
    check(16'(ack), 16'h0001);
    host.byte_tx(idx, ack);
    host.byte_tx(d, ack);
    check(16'(ack), 16'h0001);
    host.stop();
  endtask
  // index by write, repeated start, then read
  task automatic reg_rd(input logic [7:0] idx, input logic last, output logic [7:0] d);
    host.start();
    host.byte_tx(cct_pkg::ADDR_WR, ack);
    host.byte_tx(idx, ack);
    host.start();
    host.byte_tx(cct_pkg::ADDR_RD, ack);
    check(16'(ack), 16'h0001);
    host.byte_rx(last, d);
  endtask
  // one 16-slot voice word, slot 1 flagged by frame
  task automatic pcm_send(input logic [15:0] w);
    for (int i = 0; i < 16; i++) begin
      pcm_frame = (i == 0);
      pcm_bit_en = ~pcm_bit_en;
      pcm_din = w[15-i];
      host.step(1);
      pcm_bit_en = ~pcm_bit_en;
      host.step(1);
    end
  endtask
  task automatic pop();
    rx_sample_ready = rx_sample_valid; // take the head only when offered
    host.step(1);
    rx_sample_ready = 1'b0;
    host.step(1);
  endtask

  task automatic t_reset();
    check(16'(side_atten_db), 16'h000C);
    check(16'(vol_atten_db), 16'h0000);
    check(16'({side_mute, ear_mute, ear_sel_diff}), 16'h0005);
    reg_rd(cct_pkg::IDX_PWR, 1'b1, rd);
    host.stop();
    check(16'(rd), 16'(cct_pkg::RST_PWR));
    $display("reset test done");
  endtask
  task automatic t_gain();
    for (int c = 0; c <= 6; c++) begin
      reg_wr(cct_pkg::IDX_TXPGA, 8'h40 | 8'(c));
      check(16'(side_atten_db), 16'(12 + 2 * c));
    end
    for (int c = 0; c <= 9; c++) begin
      reg_wr(cct_pkg::IDX_RXPGA, 8'h70 | 8'(c));
      check(16'(vol_atten_db), 16'(2 * c));
    end
    reg_wr(cct_pkg::IDX_PWR, 8'h7E);
    check(16'({side_mute, ear_mute}), 16'h0001);
    reg_wr(cct_pkg::IDX_PWR, 8'hF6);
    check(16'({side_mute, ear_mute}), 16'h0002);
    $display("gain test done");
  endtask
  task automatic t_bus();
    host.start();
    host.byte_tx(8'hE4, ack);
    check(16'(ack), 16'h0000);
    host.stop();
    reg_wr(8'h06, 8'h5A);
    reg_rd(8'h06, 1'b1, rd);
    host.stop();
    check(16'(rd), 16'(cct_pkg::RD_UNMAPPED));
    // burst write of a dual tone, then burst read back
    host.start();
    host.byte_tx(cct_pkg::ADDR_WR, ack);
    host.byte_tx(cct_pkg::IDX_TONE_HI, ack);
    host.byte_tx(8'h9B, ack);
    host.byte_tx(8'h59, ack);
    host.stop();
    reg_rd(cct_pkg::IDX_TONE_HI, 1'b0, rd);
    host.byte_rx(1'b1, rd2);
    check(16'({sda_o, sda_oe}), 16'h0000);
    host.stop();
    check(16'({rd, rd2}), 16'h9B59);
    $display("bus test done");
  endtask
  task automatic t_voice();
    reg_wr(cct_pkg::IDX_MODE, 8'h12);
    pcm_send(16'hC3A5);
    check(16'({rx_sample_valid, rx_sample_data}), 16'h80C3);
    pop();
    reg_wr(cct_pkg::IDX_MODE, 8'h02);
    pcm_send({15'h2D2D, 1'b1});
    check(16'({rx_sample_valid, rx_sample_data}), 16'hAD2D);
    pop();
    // fill past depth with consumer stalled, then drain
    reg_wr(cct_pkg::IDX_MODE, 8'h12);
    for (int i = 1; i <= 9; i++) pcm_send({8'(8'h10 + i), 8'hFF});
    check(16'(rx_fifo_ready), 16'h0000);
    for (int i = 1; i <= 8; i++) begin
      check(16'(rx_sample_data), 16'(8'h10 + i));
      pop();
    end
    check(16'({rx_sample_valid, rx_fifo_ready}), 16'h0001);
    $display("voice test done");
  endtask
  task automatic t_tone();
    logic [7:0] prev;
    int ones;
    int pk_hi;
    int pk_lo;
    reg_wr(cct_pkg::IDX_MODE, 8'h4A);
    reg_wr(cct_pkg::IDX_TONE_LO, 8'h59);
    prev = tone_sample;
    for (int k = 0; k < 200 && tone_sample === prev; k++) host.step(1);
    host.step(6);
    check(16'(tone_sample), 16'(8'({tone_hi_sample[6], tone_hi_sample})
      + 8'({{2{tone_lo_sample[5]}}, tone_lo_sample})));
    ones = 0;
    for (int k = 0; k < 256; k++) begin
      ones += int'(buzzer_pdm_out === 1'b1);
      host.step(1);
    end
    check(16'(ones > 0), 16'h0001);
    // same code in both: peaks must differ by the high tone's boost
    reg_wr(cct_pkg::IDX_TONE_HI, 8'h80);
    reg_wr(cct_pkg::IDX_TONE_LO, 8'h80);
    pk_hi = 0;
    pk_lo = 0;
    for (int k = 0; k < 320; k++) begin
      if ($signed(tone_hi_sample) > pk_hi) pk_hi = $signed(tone_hi_sample);
      if ($signed(tone_lo_sample) > pk_lo) pk_lo = $signed(tone_lo_sample);
      host.step(1);
    end
    check(16'(pk_hi), 16'h0027);
    check(16'(pk_lo), 16'h001F);
    reg_wr(cct_pkg::IDX_MODE, 8'h02);
    host.step(64);
    check(16'({tone_sample, buzzer_pdm_out}), 16'h0000);
    $display("tone test done");
  endtask

  initial begin
    rst = 1'b1;
    pcm_frame = 1'b0;
    pcm_bit_en = 1'b0;
    pcm_din = 1'b0;
    rx_sample_ready = 1'b0;
    repeat (20) @(posedge clock);
    #1 rst = 1'b0;
    host.step(2);
    t_reset();
    t_gain();
    t_bus();
    t_voice();
    t_tone();
    test_done();
  end
endmodule
`default_nettype wire

// file: test/cct_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module cct_host_model (
  // clock
  input wire logic clock,
  // bus lines
  output logic     scl,
  output logic     sda_pull,
  input wire logic sda
);
  // idle bus: both lines high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // every change lands just after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // data falls with clock high; also serves as repeated start
  task automatic start();
    sda_pull = 1'b0;
    step(2);
    scl = 1'b1;
    step(4);
    sda_pull = 1'b1;
    step(4);
    scl = 1'b0;
    step(2);
  endtask
  // data rises with clock high
  task automatic stop();
    sda_pull = 1'b1;
    step(2);
    scl = 1'b1;
    step(4);
    sda_pull = 1'b0;
    step(4);
  endtask
  // data set in clock low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    // entered with clock low, so two toggles make one pulse
    sda_pull = !b;
    step(2);
    scl = ~scl;
    step(3);
    r = sda;
    step(3);
    scl = ~scl;
    step(2);
  endtask
  // msb first, ninth clock for the answer
  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // master nack on the last byte ends the read
  task automatic byte_rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire
